// ===== bench/cif_cpu_iface_chk.sv
// Port assertions for the CPU interface
`timescale 1ns/1ps
`include "cif_regs.svh"
module cif_cpu_iface_chk #(
    parameter logic [7:0] PE_ID = 8'h00 // Served element
) (
    input wire logic clock_in, // Core clock
    input wire logic rst_in, // Async reset
    input wire logic ce_in, // Clock enable
    input wire logic [7:0] addr_in, // Address
    input wire logic [31:0] wr_data_in, // Write data
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    input wire logic [31:0] rd_data_out, // Read data
    input wire cif_pkg::cif_cand_t cand_in, // Top pending
    input wire logic fiq_out, // Group 0 line
    input wire logic irq_out, // Group 1 line
    input wire logic ack_valid_out, // Ack pulse
    input wire cif_pkg::cif_ack_t ack_out, // Ack report
    input wire logic deact_valid_out, // Deact pulse
    input wire logic [15:0] deact_id_out // Deact id
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////////
    // Read data stands one cycle only
    rd_quiet_a: assert property (
        ce_in && !rd_in |=> rd_data_out == 32'h0) else $error("read data not cleared");
    // Activation only from an acknowledge read
    ack_cause_a: assert property (
        ack_valid_out |-> $past(rd_in) && ($past(addr_in) == `CIF_ACK0_OFS
        || $past(addr_in) == `CIF_ACK1_OFS)) else $error("ack without ack read");
    ack_data_a: assert property (
        ack_valid_out |-> rd_data_out == {16'h0, ack_out.id} && ack_out.pe == PE_ID)
        else $error("ack id or element wrong");
    // Request lines fall right after a taking read
    ack_line_a: assert property (
        ack_valid_out |-> !fiq_out && !irq_out) else $error("line held after ack");
    ack_state_a: assert property (
        ack_valid_out && ack_out.kind != cif_pkg::CIF_LPI |-> ack_out.new_state ==
        ($past(cand_in.again) ? cif_pkg::CIF_ACT_PEND : cif_pkg::CIF_ACTIVE))
        else $error("ack new state wrong");
    lpi_clear_a: assert property (
        ack_valid_out |-> ack_out.clear_lpi == (ack_out.kind == cif_pkg::CIF_LPI)
        && (ack_out.kind != cif_pkg::CIF_LPI || ack_out.new_state == cif_pkg::CIF_INACTIVE))
        else $error("locality clear wrong");
    sgi_self_a: assert property (
        ack_valid_out |-> ack_out.clear_sgi_self == (ack_out.kind == cif_pkg::CIF_SGI))
        else $error("software clear wrong");
    deact_cause_a: assert property (
        deact_valid_out |-> $past(wr_in) && deact_id_out == $past(wr_data_in[15:0]))
        else $error("deact without write");
    // Lines only for an offered, not active-and-pending candidate
    fiq_gate_a: assert property (
        fiq_out |-> $past(cand_in.valid) && !$past(cand_in.active_pend)
        && $past(cand_in.grp) == cif_pkg::CIF_GRP0) else $error("fiq without cause");
    irq_gate_a: assert property (
        irq_out |-> $past(cand_in.valid) && !$past(cand_in.active_pend)
        && $past(cand_in.grp) != cif_pkg::CIF_GRP0) else $error("irq without cause");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind cif_cpu_iface cif_cpu_iface_chk #(.PE_ID(PE_ID)) chk (
    .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .cand_in(cand_in), .fiq_out(fiq_out), .irq_out(irq_out),
    .ack_valid_out(ack_valid_out), .ack_out(ack_out),
    .deact_valid_out(deact_valid_out), .deact_id_out(deact_id_out));

// ===== bench/cif_route_model.sv
// Routing-side model: four interrupt slots offering the top pending one
`timescale 1ns/1ps
module cif_route_model (
    input wire logic clock_in, // Core clock
    input wire logic ack_valid_in, // Ack pulse
    input wire cif_pkg::cif_ack_t ack_in, // Ack report
    input wire logic deact_valid_in, // Deact pulse
    input wire logic [15:0] deact_id_in, // Deact id
    output cif_pkg::cif_cand_t cand_out // Top pending
);
    cif_pkg::cif_entry_t [3:0] slot;
    cif_pkg::cif_state_t [3:0] st = '0;
    logic [3:0] again = '0;
    // Load a slot as pending; bench calls it between edges
    task automatic put(input int i, input logic [15:0] id, input logic [7:0] pr,
        input logic [1:0] grp, input logic [1:0] kind, input logic agn);
    begin
        slot[i] = {id, pr, grp, kind};
        again[i] = agn;
        st[i] = cif_pkg::CIF_PENDING;
    end
    endtask
    // Lowest value wins; active-and-pending is still offered, flagged
    always_comb
    begin
        cand_out = '0;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i][0] && (!cand_out.valid || slot[i].prio < cand_out.prio))
            begin
                cand_out = {1'b1, slot[i].id, slot[i].prio, slot[i].grp, slot[i].kind,
                    1'b0, again[i], st[i] == cif_pkg::CIF_ACT_PEND};
            end
        end
    end
    // Apply ack and deact reports to the matching slot only
    always @(posedge clock_in)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (ack_valid_in && st[i][0] && slot[i].id == ack_in.id)
                st[i] <= ack_in.clear_lpi ? cif_pkg::CIF_INACTIVE : ack_in.new_state;
            if (deact_valid_in && st[i][1] && slot[i].id == deact_id_in)
                st[i] <= st[i][0] ? cif_pkg::CIF_PENDING : cif_pkg::CIF_INACTIVE;
        end
    end
endmodule

// ===== bench/tb.sv
// Self-checking bench for the CPU interface
`timescale 1ns/1ps
`include "cif_regs.svh"
module tb;
    logic clock_in;
    logic rst_in;
    logic ce_in;
    logic [7:0] addr_in;
    logic [31:0] wr_data_in;
    logic wr_in;
    logic rd_in;
    logic [31:0] rd_data_out;
    cif_pkg::cif_cand_t cand_in;
    logic fiq_out, irq_out, ack_valid_out, deact_valid_out;
    cif_pkg::cif_ack_t ack_out;
    logic [15:0] deact_id_out;
    int num_errors = 0;
    int check_count = 0;
    cif_cpu_iface uut (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
        .rd_data_out(rd_data_out), .cand_in(cand_in), .fiq_out(fiq_out), .irq_out(irq_out),
        .ack_valid_out(ack_valid_out), .ack_out(ack_out),
        .deact_valid_out(deact_valid_out), .deact_id_out(deact_id_out));
    cif_route_model route (.clock_in(clock_in), .ack_valid_in(ack_valid_out),
        .ack_in(ack_out), .deact_valid_in(deact_valid_out), .deact_id_in(deact_id_out),
        .cand_out(cand_in));
    ////////////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    begin
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    end
    endtask
    // One-cycle write; returns in the cycle after, where a deact pulse stands
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge clock_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge clock_in);
        wr_in <= 1'b0;
        #1;
    end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    begin
        @(posedge clock_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        check($sformatf("reg %h", a), rd_data_out, exp);
    end
    endtask
    task automatic deact(input logic v, input logic [15:0] id);
    begin
        check("deact pulse", deact_valid_out, v);
        if (v)
            check("deact id", deact_id_out, id);
    end
    endtask
    // Lines are registered, so allow two edges to settle
    task automatic lines(input logic f, input logic i);
    begin
        repeat (2) @(posedge clock_in);
        #1;
        check("fiq", fiq_out, f);
        check("irq", irq_out, i);
    end
    endtask
    task automatic finish_test();
    begin
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    // Whole run is under a hundred cycles
    initial
    begin
        #20000;
        num_errors++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_in = 1'b1;
        ce_in = 1'b1;
        addr_in = 8'h00;
        wr_data_in = 32'h0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        // Masked: queries see the candidate, acknowledge does nothing
        rd(`CIF_CTRL_OFS, 32'h0);
        rd(8'h30, 32'h0);
        route.put(0, 16'h0020, 8'h40, 2'h0, 2'h0, 1'b0);
        rd(`CIF_HPQ0_OFS, 32'h20);
        rd(`CIF_HPQ1_OFS, 32'h3ff);
        rd(`CIF_ACK0_OFS, 32'h3ff);
        rd(`CIF_RPR_OFS, 32'hff);
        lines(1'b0, 1'b0);
        $display("test masked done");
        // Secure level 1, both groups on, mask 0xf0: nested acknowledges
        wr(`CIF_CTRL_OFS, 32'h0000f023);
        rd(`CIF_CTRL_OFS, 32'h0000f023);
        lines(1'b1, 1'b0);
        rd(`CIF_ACK0_OFS, 32'h20);
        rd(`CIF_RPR_OFS, 32'h40);
        rd(`CIF_APR_OFS, 32'h100);
        lines(1'b0, 1'b0);
        route.put(1, 16'h0021, 8'h20, 2'h1, 2'h1, 1'b1);
        lines(1'b0, 1'b1);
        rd(`CIF_ACK1_OFS, 32'h21);
        check("state", ack_out.new_state, cif_pkg::CIF_ACT_PEND);
        rd(`CIF_RPR_OFS, 32'h20);
        rd(`CIF_APR_OFS, 32'h110);
        rd(`CIF_HPQ1_OFS, 32'h3ff);
        lines(1'b0, 1'b0);
        $display("test nesting done");
        // Out-of-order drop is ignored, then reverse order drops
        wr(`CIF_EOI0_OFS, 32'h20);
        deact(1'b0, 16'h0);
        rd(`CIF_RPR_OFS, 32'h20);
        wr(`CIF_EOI1_OFS, 32'h21);
        deact(1'b1, 16'h21);
        rd(`CIF_RPR_OFS, 32'h40);
        wr(`CIF_EOI0_OFS, 32'h20);
        deact(1'b1, 16'h20);
        rd(`CIF_RPR_OFS, 32'hff);
        rd(`CIF_APR_OFS, 32'h0);
        $display("test drop done");
        // Split mode: drop without deact, then explicit deact
        wr(`CIF_CTRL_OFS, 32'h0000f027);
        route.put(1, 16'h0021, 8'h20, 2'h1, 2'h1, 1'b0);
        rd(`CIF_ACK1_OFS, 32'h21);
        wr(`CIF_EOI1_OFS, 32'h21);
        deact(1'b0, 16'h0);
        rd(`CIF_RPR_OFS, 32'hff);
        wr(`CIF_DEACT_OFS, 32'h21);
        deact(1'b1, 16'h21);
        rd(`CIF_HPQ1_OFS, 32'h3ff);
        $display("test split done");
        // Locality interrupt: pending cleared, no active state
        route.put(2, 16'h2000, 8'h10, 2'h1, 2'h3, 1'b0);
        rd(`CIF_ACK1_OFS, 32'h2000);
        check("lpi clear", ack_out.clear_lpi, 1'b1);
        rd(`CIF_HPQ1_OFS, 32'h3ff);
        wr(`CIF_EOI1_OFS, 32'h2000);
        rd(`CIF_RPR_OFS, 32'hff);
        $display("test locality done");
        // Top level, secure group 0 read with a secure, then a non-secure group 1 candidate
        route.put(3, 16'h0030, 8'h50, 2'h1, 2'h2, 1'b0);
        wr(`CIF_CTRL_OFS, 32'h0000f063);
        rd(`CIF_ACK0_OFS, 32'h3fc);
        rd(`CIF_RPR_OFS, 32'hff);
        route.put(3, 16'h0030, 8'h50, 2'h2, 2'h2, 1'b0);
        rd(`CIF_ACK0_OFS, 32'h3fd);
        $display("test top level done");
        // Clock enable low: a write given while frozen is lost
        @(posedge clock_in);
        ce_in <= 1'b0;
        wr(`CIF_CTRL_OFS, 32'h0);
        @(posedge clock_in);
        ce_in <= 1'b1;
        rd(`CIF_CTRL_OFS, 32'h0000f063);
        $display("test freeze done");
        finish_test();
    end
endmodule

// ===== core/cif_ack_decide.sv
// Acknowledge and highest-pending decision for the top pending interrupt
`timescale 1ns/1ps
`include "cif_regs.svh"
module cif_ack_decide (
    input wire cif_pkg::cif_cand_t cand_in, // Top pending interrupt
    input wire logic grp0_en_in, // Group 0 enabled
    input wire logic grp1_en_in, // Group 1 enabled
    input wire logic ns_in, // Non-secure state
    input wire logic at_top_in, // Highest exception level
    input wire logic [7:0] pmr_in, // Priority mask
    input wire logic [7:0] run_prio_in, // Running priority
    output logic sig0_out, // Group 0 may be signalled
    output logic sig1_out, // Group 1 may be signalled
    output logic take0_out, // Group 0 read activates
    output logic take1_out, // Group 1 read activates
    output logic [15:0] ack0_id_out, // Group 0 read value
    output logic [15:0] ack1_id_out, // Group 1 read value
    output logic [15:0] hpq0_id_out, // Group 0 query value
    output logic [15:0] hpq1_id_out // Group 1 query value
);
    logic secure;
    logic is_g0;
    logic mine1;
    logic live;
    logic enabled;
    logic ok;

    // Pending, not active-and-pending, group enabled and above both limits
    assign live = cand_in.valid && !cand_in.active_pend;
    assign is_g0 = (cand_in.grp == cif_pkg::CIF_GRP0);
    assign enabled = is_g0 ? grp0_en_in : grp1_en_in;
    assign ok = live && enabled && (cand_in.prio < pmr_in)
        && (cand_in.prio < run_prio_in);
    assign secure = !ns_in || at_top_in;
    // Group 1 read owns the group of the current security state, and both groups at top level
    assign mine1 = (cand_in.grp == cif_pkg::CIF_GRP1NS) ? (ns_in || at_top_in)
        : ((cand_in.grp == cif_pkg::CIF_GRP1S) && secure);

    assign sig0_out = ok && is_g0;
    assign sig1_out = ok && !is_g0;
    assign take0_out = ok && is_g0;
    assign take1_out = ok && mine1;

    // Group 0 read; at top level a group 1 interrupt names the needed state
    always_comb
    begin
        if (take0_out)
            ack0_id_out = cand_in.id;
        else if (ok && at_top_in && secure && cand_in.grp == cif_pkg::CIF_GRP1S)
            ack0_id_out = `CIF_ID_TO_SECURE;
        else if (ok && at_top_in && secure && cand_in.grp == cif_pkg::CIF_GRP1NS)
            ack0_id_out = `CIF_ID_TO_NONSECURE;
        else
            ack0_id_out = `CIF_ID_SPURIOUS;
    end

    assign ack1_id_out = take1_out ? cand_in.id : `CIF_ID_SPURIOUS;
    assign hpq0_id_out = (live && is_g0) ? cand_in.id : `CIF_ID_SPURIOUS;
    assign hpq1_id_out = (live && mine1) ? cand_in.id : `CIF_ID_SPURIOUS;
endmodule

// ===== core/cif_cpu_iface.sv
// Physical CPU interface: acknowledge, running priority, drop and deactivation
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`include "cif_regs.svh"
module cif_cpu_iface #(
    parameter int DEPTH = 8, // Nesting depth of active interrupts
    parameter logic [7:0] PE_ID = 8'h00 // Index of the served element
) (
    input wire logic clock_in, // Core clock, 250 MHz
    input wire logic rst_in, // Async reset, high
    input wire logic ce_in, // Clock enable
    input wire logic [7:0] addr_in, // Register byte address
    input wire logic [31:0] wr_data_in, // Register write data
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    output logic [31:0] rd_data_out, // Read data, next cycle
    input wire cif_pkg::cif_cand_t cand_in, // Top pending from routing
    output logic fiq_out, // Group 0 request line
    output logic irq_out, // Group 1 request line
    output logic ack_valid_out, // Acknowledge report pulse
    output cif_pkg::cif_ack_t ack_out, // Acknowledge report
    output logic deact_valid_out, // Deactivation pulse
    output logic [15:0] deact_id_out // Interrupt to deactivate
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [31:0] ctrl_r;
    logic [31:0] rd_data_r;
    logic fiq_r;
    logic irq_r;
    logic ack_valid_r;
    cif_pkg::cif_ack_t ack_r;
    cif_pkg::cif_ack_t ack_nxt;
    logic deact_valid_r;
    logic [15:0] deact_id_r;

    logic grp0_en;
    logic grp1_en;
    logic split_mode;
    logic top_split;
    logic ns_bit;
    logic [1:0] exc_level;
    logic [7:0] pmr;
    logic at_top;
    logic split_now;

    cif_pkg::cif_entry_t top_entry;
    cif_pkg::cif_entry_t push_entry;
    logic stk_empty;
    logic stk_full;
    logic [31:0] apr;
    logic [7:0] run_prio;

    logic sig0;
    logic sig1;
    logic take0;
    logic take1;
    logic [15:0] ack0_id;
    logic [15:0] ack1_id;
    logic [15:0] hpq0_id;
    logic [15:0] hpq1_id;

    logic rd_ack0;
    logic rd_ack1;
    logic take;
    logic eoi_wr0;
    logic eoi_wr1;
    logic [15:0] wr_id;
    logic wr_id_rsvd;
    logic grp_match;
    logic eoi_ok;
    logic dir_ok;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////////
    // Control fields

    assign grp0_en = ctrl_r[`CIF_CTRL_GRP0_EN];
    assign grp1_en = ctrl_r[`CIF_CTRL_GRP1_EN];
    assign split_mode = ctrl_r[`CIF_CTRL_SPLIT];
    assign top_split = ctrl_r[`CIF_CTRL_TOP_SPLIT];
    assign ns_bit = ctrl_r[`CIF_CTRL_NS];
    assign exc_level = ctrl_r[`CIF_CTRL_EL_LO +: 2];
    assign pmr = ctrl_r[`CIF_CTRL_PMR_LO +: 8];
    assign at_top = (exc_level == `CIF_EL_TOP);

    // The top level has its own split control, lower levels share one
    assign split_now = at_top ? top_split : split_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Active interrupt stack and running priority

    // Drop order is forced LIFO, so the stack top is always the running one
    cif_prio_stack #(
        .DEPTH(DEPTH)
    ) u_stack (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .push_in(take),
        .pop_in(eoi_ok),
        .push_entry_in(push_entry),
        .top_out(top_entry),
        .empty_out(stk_empty),
        .full_out(stk_full),
        .apr_out(apr)
    );

    // Popping exposes the earlier entry, i.e. the priority before acknowledge
    assign run_prio = stk_empty ? `CIF_IDLE_PRIO : top_entry.prio;
    // Empty stack after the last drop yields the idle value
    // Pop restores the previous running priority

    assign push_entry.id = cand_in.id;
    assign push_entry.prio = cand_in.prio;
    assign push_entry.grp = cand_in.grp;
    assign push_entry.kind = cand_in.kind;

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge decision

    // Routing infrastructure already prioritised this candidate
    cif_ack_decide u_decide (
        .cand_in(cand_in),
        .grp0_en_in(grp0_en),
        .grp1_en_in(grp1_en),
        .ns_in(ns_bit),
        .at_top_in(at_top),
        .pmr_in(pmr),
        .run_prio_in(run_prio),
        .sig0_out(sig0),
        .sig1_out(sig1),
        .take0_out(take0),
        .take1_out(take1),
        .ack0_id_out(ack0_id),
        .ack1_id_out(ack1_id),
        .hpq0_id_out(hpq0_id),
        .hpq1_id_out(hpq1_id)
    );

    assign rd_ack0 = rd_in && (addr_in == `CIF_ACK0_OFS);
    assign rd_ack1 = rd_in && (addr_in == `CIF_ACK1_OFS);
    // A full stack refuses activation; the read then reports spurious
    assign take = ((rd_ack0 && take0) || (rd_ack1 && take1)) && !stk_full;

    ////////////////////////////////////////////////////////////////////////////
    // End of interrupt and deactivation decode

    assign eoi_wr0 = wr_in && (addr_in == `CIF_EOI0_OFS);
    assign eoi_wr1 = wr_in && (addr_in == `CIF_EOI1_OFS);
    assign wr_id = wr_data_in[15:0];
    assign wr_id_rsvd = (wr_id >= `CIF_ID_TO_SECURE) && (wr_id <= `CIF_ID_SPURIOUS);
    assign grp_match = eoi_wr0 ? (top_entry.grp == cif_pkg::CIF_GRP0)
        : (top_entry.grp != cif_pkg::CIF_GRP0);
    // Only the most recent acknowledge may be dropped; others are ignored
    assign eoi_ok = (eoi_wr0 || eoi_wr1) && !stk_empty && !wr_id_rsvd
        && (wr_id == top_entry.id) && grp_match;
    // Explicit deactivation only makes sense in split mode
    assign dir_ok = wr_in && (addr_in == `CIF_DEACT_OFS) && split_now
        && !wr_id_rsvd;

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            ctrl_r <= `CIF_CTRL_RESET;
        else if (ce_in && wr_in && (addr_in == `CIF_CTRL_OFS))
            ctrl_r <= wr_data_in & `CIF_CTRL_MASK;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    // Unmapped and write-only words read as zero
    always_comb
    begin
        case (addr_in)
            `CIF_CTRL_OFS: rd_mux = ctrl_r;
            `CIF_HPQ0_OFS: rd_mux = {16'h0000, hpq0_id};
            `CIF_HPQ1_OFS: rd_mux = {16'h0000, hpq1_id};
            `CIF_ACK0_OFS: rd_mux = {16'h0000, stk_full ? `CIF_ID_SPURIOUS : ack0_id};
            `CIF_ACK1_OFS: rd_mux = {16'h0000, stk_full ? `CIF_ID_SPURIOUS : ack1_id};
            `CIF_RPR_OFS: rd_mux = {24'h000000, run_prio};
            `CIF_APR_OFS: rd_mux = apr;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            rd_data_r <= 32'h00000000;
        else if (ce_in)
            rd_data_r <= rd_in ? rd_mux : 32'h00000000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request lines to the one served element

    // Registered with the taking cycle masked, so the line falls on the edge where an acknowledge raises
    // the running priority; a higher candidate raises it again to preempt
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            fiq_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else if (ce_in)
        begin
            fiq_r <= sig0 && !take;
            irq_r <= sig1 && !take;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge report

    // State left behind in the routing infrastructure after activation
    always_comb
    begin
        ack_nxt.id = cand_in.id;
        ack_nxt.kind = cand_in.kind;
        ack_nxt.pe = PE_ID;
        ack_nxt.clear_lpi = (cand_in.kind == cif_pkg::CIF_LPI);
        ack_nxt.clear_sgi_self = (cand_in.kind == cif_pkg::CIF_SGI);
        if (cand_in.kind == cif_pkg::CIF_LPI)
            ack_nxt.new_state = cif_pkg::CIF_INACTIVE;
        else if (cand_in.again)
            ack_nxt.new_state = cif_pkg::CIF_ACT_PEND;
        else
            ack_nxt.new_state = cif_pkg::CIF_ACTIVE;
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ack_valid_r <= 1'b0;
            ack_r <= '0;
        end
        else if (ce_in)
        begin
            ack_valid_r <= take;
            if (take)
                ack_r <= ack_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Deactivation report

    // Combined mode deactivates with the drop; locality ones have no active state
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            deact_valid_r <= 1'b0;
            deact_id_r <= 16'h0000;
        end
        else if (ce_in)
        begin
            if (eoi_ok && !split_now && (top_entry.kind != cif_pkg::CIF_LPI))
            begin
                deact_valid_r <= 1'b1;
                deact_id_r <= top_entry.id;
            end
            else if (dir_ok)
            begin
                deact_valid_r <= 1'b1;
                deact_id_r <= wr_id;
            end
            else
                deact_valid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rd_data_out = rd_data_r;
    assign fiq_out = fiq_r;
    assign irq_out = irq_r;
    assign ack_valid_out = ack_valid_r;
    assign ack_out = ack_r;
    assign deact_valid_out = deact_valid_r;
    assign deact_id_out = deact_id_r;
endmodule

// ===== core/cif_pkg.sv
// Types shared by the CPU interface modules
package cif_pkg;
    typedef enum logic [1:0] {
        CIF_GRP0 = 2'b00,
        CIF_GRP1S = 2'b01,
        CIF_GRP1NS = 2'b10
    } cif_group_t;
    typedef enum logic [1:0] {
        CIF_SGI = 2'b00,
        CIF_PPI = 2'b01,
        CIF_SPI = 2'b10,
        CIF_LPI = 2'b11
    } cif_kind_t;
    typedef enum logic [1:0] {
        CIF_INACTIVE = 2'b00,
        CIF_PENDING = 2'b01,
        CIF_ACTIVE = 2'b10,
        CIF_ACT_PEND = 2'b11
    } cif_state_t;
    // Top pending interrupt offered by the routing infrastructure
    typedef struct packed {
        logic valid;
        logic [15:0] id;
        logic [7:0] prio;
        cif_group_t grp;
        cif_kind_t kind;
        logic edge_trig;
        logic again;
        logic active_pend;
    } cif_cand_t;
    // Acknowledge report back to the routing infrastructure
    typedef struct packed {
        logic [15:0] id;
        cif_kind_t kind;
        cif_state_t new_state;
        logic clear_lpi;
        logic clear_sgi_self;
        logic [7:0] pe;
    } cif_ack_t;
    // One acknowledged interrupt awaiting its priority drop
    typedef struct packed {
        logic [15:0] id;
        logic [7:0] prio;
        cif_group_t grp;
        cif_kind_t kind;
    } cif_entry_t;
endpackage

// ===== core/cif_prio_stack.sv
// Stack of acknowledged interrupts awaiting priority drop
`timescale 1ns/1ps
module cif_prio_stack #(
    parameter int DEPTH = 8
) (
    input wire logic clock_in, // Core clock
    input wire logic rst_in, // Async reset, high
    input wire logic ce_in, // Clock enable
    input wire logic push_in, // Record an acknowledge
    input wire logic pop_in, // Priority drop of top
    input wire cif_pkg::cif_entry_t push_entry_in, // Entry to record
    output cif_pkg::cif_entry_t top_out, // Most recent entry
    output logic empty_out, // No entry held
    output logic full_out, // No room left
    output logic [31:0] apr_out // Active priority groups
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int IW = $clog2(DEPTH);

    cif_pkg::cif_entry_t mem [DEPTH];
    logic [CW-1:0] count_r;
    logic [CW-1:0] top_cnt;
    logic [31:0] acc [DEPTH+1];

    ////////////////////////////////////////////////////////////////////////////
    // Depth counter; entries above it are stale, so the array needs no reset
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            count_r <= '0;
        else if (ce_in && push_in && !full_out)
            count_r <= count_r + CW'(1);
        else if (ce_in && pop_in && !empty_out)
            count_r <= count_r - CW'(1);
    end

    // Entry store
    always_ff @(posedge clock_in)
    begin
        if (ce_in && push_in && !full_out)
            mem[count_r[IW-1:0]] <= push_entry_in;
    end

    assign top_cnt = count_r - CW'(1);
    assign top_out = mem[top_cnt[IW-1:0]];
    assign empty_out = (count_r == '0);
    assign full_out = (count_r == CW'(DEPTH));

    ////////////////////////////////////////////////////////////////////////////
    // One bit per priority group still held by a live entry
    assign acc[0] = 32'h0;
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_apr
        assign acc[i+1] = acc[i] | ((CW'(i) < count_r) ?
            (32'h1 << mem[i].prio[7:3]) : 32'h0);
    end
    assign apr_out = acc[DEPTH];
endmodule

// ===== core/cif_regs.svh
// Register offsets, control fields, reset values and special identifiers
`ifndef CIF_REGS_SVH
`define CIF_REGS_SVH
// Byte offsets of the register words
`define CIF_CTRL_OFS 8'h00
`define CIF_HPQ0_OFS 8'h04
`define CIF_HPQ1_OFS 8'h08
`define CIF_ACK0_OFS 8'h0c
`define CIF_ACK1_OFS 8'h10
`define CIF_EOI0_OFS 8'h14
`define CIF_EOI1_OFS 8'h18
`define CIF_DEACT_OFS 8'h1c
`define CIF_RPR_OFS 8'h20
`define CIF_APR_OFS 8'h24
// Control register fields
`define CIF_CTRL_GRP0_EN 0
`define CIF_CTRL_GRP1_EN 1
`define CIF_CTRL_SPLIT 2
`define CIF_CTRL_TOP_SPLIT 3
`define CIF_CTRL_NS 4
`define CIF_CTRL_EL_LO 5
`define CIF_CTRL_PMR_LO 8
`define CIF_CTRL_MASK 32'h0000ff7f
`define CIF_CTRL_RESET 32'h00000000
// Priorities and identifiers
`define CIF_IDLE_PRIO 8'hff
`define CIF_EL_TOP 2'h3
`define CIF_ID_TO_SECURE 16'h03fc
`define CIF_ID_TO_NONSECURE 16'h03fd
`define CIF_ID_SPURIOUS 16'h03ff
`endif
